// [rtl/gpa_regs.svh]
// Purpose: Register offsets, field widths and reset values for the three-port GPIO block
// Assumes: Byte-wide register port, one register per byte address
// Notes:   Definitions only; included by bare name
`ifndef GPA_REGS_SVH
`define GPA_REGS_SVH

// ****************************************************************
// Register offsets (byte addresses on the register port)
// ****************************************************************
`define GPA_OFS_KBD_LATCH     8'h00
`define GPA_OFS_ANALOG_LATCH  8'h01
`define GPA_OFS_PLAIN_LATCH   8'h02
`define GPA_OFS_KBD_DIR       8'h04
`define GPA_OFS_ANALOG_DIR    8'h05
`define GPA_OFS_PLAIN_DIR     8'h06
`define GPA_OFS_KBD_PUE       8'h0d
`define GPA_OFS_PLAIN_PUE     8'h0e

// ****************************************************************
// Field widths, bus widths and reset values
// ****************************************************************
`define GPA_ADDR_W            8
`define GPA_DATA_W            8
`define GPA_KBD_W             4
`define GPA_ANALOG_W          6
`define GPA_PLAIN_W           2
`define GPA_ADC_CH_W          3
`define GPA_DIR_RESET         8'h00
`define GPA_PUE_RESET         8'h00
`define GPA_UNMAPPED_READ     8'h00

`endif

// [rtl/gpa_pkg.sv]
// Purpose: Types shared by the three-port GPIO block
// Assumes: Constants live in gpa_regs.svh
// Notes:   One-hot register select used by the address decoder
package gpa_pkg;

    // ****************************************************************
    // Register select, one-hot
    // ****************************************************************
    typedef enum logic [8:0] {
        GPA_SEL_NONE         = 9'h001,
        GPA_SEL_KBD_LATCH    = 9'h002,
        GPA_SEL_ANALOG_LATCH = 9'h004,
        GPA_SEL_PLAIN_LATCH  = 9'h008,
        GPA_SEL_KBD_DIR      = 9'h010,
        GPA_SEL_ANALOG_DIR   = 9'h020,
        GPA_SEL_PLAIN_DIR    = 9'h040,
        GPA_SEL_KBD_PUE      = 9'h080,
        GPA_SEL_PLAIN_PUE    = 9'h100
    } gpa_sel_t;

endpackage

// [rtl/gpa_port_slice.sv]
// Purpose: One GPIO port: data latch, direction, pullup enable, pin sync, read mux
// Assumes: Single clock, synchronous active-low reset
// Notes:   Data latch is deliberately outside the reset
`timescale 1ns/10ps
`default_nettype none
module gpa_port_slice
    import gpa_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter bit HAS_PULLUP = 1'b1
)
(
    input wire logic clk,                 // System clock
    input wire logic rstn,                // Sync reset, active low
    input wire logic wrLatch,             // Write data latch
    input wire logic wrDir,               // Write direction
    input wire logic wrPue,               // Write pullup enable
    input wire logic [WIDTH-1:0] wrData,  // Write data
    input wire logic [WIDTH-1:0] padIn,   // Raw pin levels
    input wire logic [WIDTH-1:0] analogSel, // Pins taken by converter
    output logic [WIDTH-1:0] latchQ,      // Latch value, drives pad
    output logic [WIDTH-1:0] dirQ,        // Direction bits
    output logic [WIDTH-1:0] pueQ,        // Pullup enable bits
    output logic [WIDTH-1:0] pinLevel,    // Synchronised pin level
    output logic [WIDTH-1:0] readData,    // Data register read value
    output logic [WIDTH-1:0] padOe,       // Output buffer enable
    output logic [WIDTH-1:0] pullupOn     // Pullup device on
);

    logic [WIDTH-1:0] latch_reg;
    logic [WIDTH-1:0] latch_next;
    logic [WIDTH-1:0] dir_reg;
    logic [WIDTH-1:0] dir_next;
    logic [WIDTH-1:0] pue_reg;
    logic [WIDTH-1:0] pue_next;
    logic [WIDTH-1:0] oe_reg;
    logic [WIDTH-1:0] oe_next;
    logic [WIDTH-1:0] pu_reg;
    logic [WIDTH-1:0] pu_next;
    logic [WIDTH-1:0] sync1_reg;
    logic [WIDTH-1:0] sync2_reg;

    // ****************************************************************
    // Control next values
    // ****************************************************************
    always_comb
    begin
        latch_next = wrLatch ? wrData : latch_reg;
        dir_next = wrDir ? wrData : dir_reg;
        pue_next = (wrPue && HAS_PULLUP) ? wrData : pue_reg;
        oe_next = dir_next & ~analogSel;
        // pullup only on inputs, same edge as direction
        pu_next = pue_next & ~dir_next;
    end

    always_ff @(posedge clk)
    begin
        latch_reg <= latch_next;
    end

    // Direction, pullup and buffer state
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            dir_reg <= '0;
            pue_reg <= '0;
            oe_reg <= '0;
            pu_reg <= '0;
        end
        else
        begin
            dir_reg <= dir_next;
            pue_reg <= pue_next;
            oe_reg <= oe_next;
            pu_reg <= pu_next;
        end
    end

    // Two-stage pin synchroniser; only stage two is read
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= padIn;
            sync2_reg <= sync1_reg;
        end
    end

    // latch for outputs, pin for inputs
    assign readData = (dir_reg & latch_reg) | (~dir_reg & sync2_reg);
    assign latchQ = latch_reg;
    assign dirQ = dir_reg;
    assign pueQ = pue_reg;
    assign pinLevel = sync2_reg;
    assign padOe = oe_reg;
    assign pullupOn = pu_reg;

endmodule // gpa_port_slice
`default_nettype wire

// [rtl/gpa_ports_abc.sv]
// Purpose: GPIO logic for the keyboard-shared, converter-shared and plain ports
// Assumes: 25 MHz clk, synchronous active-low rstn, byte register port
// Notes:   Read data appear the cycle after the read strobe, zero otherwise
`timescale 1ns/10ps
`default_nettype none
`include "gpa_regs.svh"
module gpa_ports_abc
    import gpa_pkg::*;
(
    input wire logic clk,                                  // System clock, 25 MHz
    input wire logic rstn,                                 // Sync reset, active low
    input wire logic [`GPA_ADDR_W-1:0] regAddr,            // Register address
    input wire logic [`GPA_DATA_W-1:0] regWrData,          // Register write data
    input wire logic regWr,                                // Write strobe
    input wire logic regRd,                                // Read strobe
    output logic [`GPA_DATA_W-1:0] regRdData,              // Read data, next cycle
    input wire logic [`GPA_KBD_W-1:0] kbdPadIn,            // Keyboard port pin levels
    output logic [`GPA_KBD_W-1:0] kbdPadOut,               // Keyboard port pin drive
    output logic [`GPA_KBD_W-1:0] kbdPadOe,                // Keyboard port drive enable
    output logic [`GPA_KBD_W-1:0] kbdPullupOn,             // Keyboard port pullups
    input wire logic [`GPA_ANALOG_W-1:0] analogPadIn,      // Converter port pin levels
    output logic [`GPA_ANALOG_W-1:0] analogPadOut,         // Converter port pin drive
    output logic [`GPA_ANALOG_W-1:0] analogPadOe,          // Converter port drive enable
    input wire logic [`GPA_PLAIN_W-1:0] plainPadIn,        // Plain port pin levels
    output logic [`GPA_PLAIN_W-1:0] plainPadOut,           // Plain port pin drive
    output logic [`GPA_PLAIN_W-1:0] plainPadOe,            // Plain port drive enable
    output logic [`GPA_PLAIN_W-1:0] plainPullupOn,         // Plain port pullups
    input wire logic [`GPA_KBD_W-1:0] keypadIrqPinEnables, // From keypad unit
    output logic [`GPA_KBD_W-1:0] keypadInputs,            // To keypad unit
    input wire logic adcChannelValid,                      // Converter channel active
    input wire logic [`GPA_ADC_CH_W-1:0] adcChannel,       // Converter channel number
    output logic [`GPA_ANALOG_W-1:0] analogChannelPins     // Analog switch per pin
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    gpa_sel_t sel;
    logic wrKbdLatch;
    logic wrKbdDir;
    logic wrKbdPue;
    logic wrAnalogLatch;
    logic wrAnalogDir;
    logic wrPlainLatch;
    logic wrPlainDir;
    logic wrPlainPue;
    logic [`GPA_KBD_W-1:0] kbdDir;
    logic [`GPA_KBD_W-1:0] kbdPue;
    logic [`GPA_KBD_W-1:0] kbdLevel;
    logic [`GPA_KBD_W-1:0] kbdRead;
    logic [`GPA_ANALOG_W-1:0] analogDir;
    logic [`GPA_ANALOG_W-1:0] analogPue;
    logic [`GPA_ANALOG_W-1:0] analogLevel;
    logic [`GPA_ANALOG_W-1:0] analogRead;
    logic [`GPA_PLAIN_W-1:0] plainDir;
    logic [`GPA_PLAIN_W-1:0] plainPue;
    logic [`GPA_PLAIN_W-1:0] plainLevel;
    logic [`GPA_PLAIN_W-1:0] plainRead;
    logic [`GPA_PLAIN_W-1:0] plainAnalogSel;
    logic [`GPA_KBD_W-1:0] kbdAnalogSel;
    logic [`GPA_ANALOG_W-1:0] analogPullupOn;
    logic [`GPA_DATA_W-1:0] rdData_reg;
    logic [`GPA_DATA_W-1:0] rdData_next;
    logic [`GPA_KBD_W-1:0] keypad_reg;
    logic [`GPA_KBD_W-1:0] keypad_next;
    logic [`GPA_ANALOG_W-1:0] analogSw_reg;
    logic [`GPA_ANALOG_W-1:0] analogSw_next;

    // ****************************************************************
    // Address decode
    // ****************************************************************

    // One-hot select; unmapped addresses fall to NONE
    always_comb
    begin
        case (regAddr)
            `GPA_OFS_KBD_LATCH: sel = GPA_SEL_KBD_LATCH;
            `GPA_OFS_KBD_DIR: sel = GPA_SEL_KBD_DIR;
            `GPA_OFS_ANALOG_LATCH: sel = GPA_SEL_ANALOG_LATCH;
            `GPA_OFS_ANALOG_DIR: sel = GPA_SEL_ANALOG_DIR;
            `GPA_OFS_PLAIN_LATCH: sel = GPA_SEL_PLAIN_LATCH;
            `GPA_OFS_PLAIN_DIR: sel = GPA_SEL_PLAIN_DIR;
            `GPA_OFS_KBD_PUE: sel = GPA_SEL_KBD_PUE;
            `GPA_OFS_PLAIN_PUE: sel = GPA_SEL_PLAIN_PUE;
            default: sel = GPA_SEL_NONE;
        endcase
    end

    // Write strobes; writes to unmapped addresses are dropped
    assign wrKbdLatch = regWr && (sel == GPA_SEL_KBD_LATCH);
    assign wrKbdDir = regWr && (sel == GPA_SEL_KBD_DIR);
    assign wrKbdPue = regWr && (sel == GPA_SEL_KBD_PUE);
    assign wrAnalogLatch = regWr && (sel == GPA_SEL_ANALOG_LATCH);
    assign wrAnalogDir = regWr && (sel == GPA_SEL_ANALOG_DIR);
    assign wrPlainLatch = regWr && (sel == GPA_SEL_PLAIN_LATCH);
    assign wrPlainDir = regWr && (sel == GPA_SEL_PLAIN_DIR);
    assign wrPlainPue = regWr && (sel == GPA_SEL_PLAIN_PUE);

    // ****************************************************************
    // Converter channel override
    // ****************************************************************

    // Only converter port pins can be claimed; other ports never are
    assign kbdAnalogSel = '0;
    assign plainAnalogSel = '0;

    // Decode the active channel to a one-hot pin mask
    always_comb
    begin
        analogSw_next = '0;
        if (adcChannelValid && (adcChannel < `GPA_ADC_CH_W'(`GPA_ANALOG_W)))
        begin
            analogSw_next[adcChannel] = 1'b1;
        end
    end

    // Registered so the switch and the buffer release share one edge
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            analogSw_reg <= '0;
        end
        else
        begin
            analogSw_reg <= analogSw_next;
        end
    end

    // ****************************************************************
    // Port instances
    // ****************************************************************

    // keyboard port, four pins with pullups
    gpa_port_slice #(
        .WIDTH(`GPA_KBD_W),
        .HAS_PULLUP(1'b1)
    ) u_kbd_port (
        .clk(clk),
        .rstn(rstn),
        .wrLatch(wrKbdLatch),
        .wrDir(wrKbdDir),
        .wrPue(wrKbdPue),
        .wrData(regWrData[`GPA_KBD_W-1:0]),
        .padIn(kbdPadIn),
        .analogSel(kbdAnalogSel),
        .latchQ(kbdPadOut),
        .dirQ(kbdDir),
        .pueQ(kbdPue),
        .pinLevel(kbdLevel),
        .readData(kbdRead),
        .padOe(kbdPadOe),
        .pullupOn(kbdPullupOn)
    );

    // converter port, six pins, pullup logic disabled
    gpa_port_slice #(
        .WIDTH(`GPA_ANALOG_W),
        .HAS_PULLUP(1'b0)
    ) u_analog_port (
        .clk(clk),
        .rstn(rstn),
        .wrLatch(wrAnalogLatch),
        .wrDir(wrAnalogDir),
        .wrPue(1'b0),
        .wrData(regWrData[`GPA_ANALOG_W-1:0]),
        .padIn(analogPadIn),
        .analogSel(analogSw_next),
        .latchQ(analogPadOut),
        .dirQ(analogDir),
        .pueQ(analogPue),
        .pinLevel(analogLevel),
        .readData(analogRead),
        .padOe(analogPadOe),
        .pullupOn(analogPullupOn)
    );

    // plain port, two bidirectional pins with pullups
    gpa_port_slice #(
        .WIDTH(`GPA_PLAIN_W),
        .HAS_PULLUP(1'b1)
    ) u_plain_port (
        .clk(clk),
        .rstn(rstn),
        .wrLatch(wrPlainLatch),
        .wrDir(wrPlainDir),
        .wrPue(wrPlainPue),
        .wrData(regWrData[`GPA_PLAIN_W-1:0]),
        .padIn(plainPadIn),
        .analogSel(plainAnalogSel),
        .latchQ(plainPadOut),
        .dirQ(plainDir),
        .pueQ(plainPue),
        .pinLevel(plainLevel),
        .readData(plainRead),
        .padOe(plainPadOe),
        .pullupOn(plainPullupOn)
    );

    // ****************************************************************
    // Keypad unit feed
    // ****************************************************************

    // enabled keyboard pins go to keypad unit
    always_comb
    begin
        keypad_next = kbdLevel & keypadIrqPinEnables;
    end

    // Uses the synchronised level, so the keypad unit sees no metastability
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            keypad_reg <= '0;
        end
        else
        begin
            keypad_reg <= keypad_next;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************

    // Read mux; data only in the cycle after the strobe
    always_comb
    begin
        rdData_next = `GPA_UNMAPPED_READ;
        if (regRd)
        begin
            case (sel)
                GPA_SEL_KBD_LATCH: rdData_next = {{(`GPA_DATA_W-`GPA_KBD_W){1'b0}}, kbdRead};
                GPA_SEL_KBD_DIR: rdData_next = {{(`GPA_DATA_W-`GPA_KBD_W){1'b0}}, kbdDir};
                GPA_SEL_KBD_PUE: rdData_next = {{(`GPA_DATA_W-`GPA_KBD_W){1'b0}}, kbdPue};
                GPA_SEL_ANALOG_LATCH: rdData_next = {{(`GPA_DATA_W-`GPA_ANALOG_W){1'b0}}, analogRead};
                GPA_SEL_ANALOG_DIR: rdData_next = {{(`GPA_DATA_W-`GPA_ANALOG_W){1'b0}}, analogDir};
                GPA_SEL_PLAIN_LATCH: rdData_next = {{(`GPA_DATA_W-`GPA_PLAIN_W){1'b0}}, plainRead};
                GPA_SEL_PLAIN_DIR: rdData_next = {{(`GPA_DATA_W-`GPA_PLAIN_W){1'b0}}, plainDir};
                GPA_SEL_PLAIN_PUE: rdData_next = {{(`GPA_DATA_W-`GPA_PLAIN_W){1'b0}}, plainPue};
                default: rdData_next = `GPA_UNMAPPED_READ;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rdData_reg <= `GPA_UNMAPPED_READ;
        end
        else
        begin
            rdData_reg <= rdData_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign regRdData = rdData_reg;
    assign keypadInputs = keypad_reg;
    assign analogChannelPins = analogSw_reg;

endmodule // gpa_ports_abc
`default_nettype wire

// [tb/gpa_ports_abc_monitor.sv]
// Purpose: Port-level checks for the three-port GPIO block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound into gpa_ports_abc after the module
`timescale 1ns/10ps
`default_nettype none
`include "gpa_regs.svh"
module gpa_ports_abc_monitor
(
    input wire logic clk,                                  // System clock
    input wire logic rstn,                                 // Sync reset, active low
    input wire logic [`GPA_ADDR_W-1:0] regAddr,            // Register address
    input wire logic [`GPA_DATA_W-1:0] regWrData,          // Write data
    input wire logic regWr,                                // Write strobe
    input wire logic regRd,                                // Read strobe
    input wire logic [`GPA_DATA_W-1:0] regRdData,          // Read data
    input wire logic [`GPA_KBD_W-1:0] kbdPadIn,            // Keyboard pins
    input wire logic [`GPA_KBD_W-1:0] kbdPadOut,           // Keyboard drive
    input wire logic [`GPA_KBD_W-1:0] kbdPadOe,            // Keyboard enables
    input wire logic [`GPA_KBD_W-1:0] kbdPullupOn,         // Keyboard pullups
    input wire logic [`GPA_ANALOG_W-1:0] analogPadOe,      // Converter enables
    input wire logic [`GPA_KBD_W-1:0] keypadIrqPinEnables, // Keypad enables
    input wire logic [`GPA_KBD_W-1:0] keypadInputs,        // Keypad levels
    input wire logic adcChannelValid,                      // Channel active
    input wire logic [`GPA_ADC_CH_W-1:0] adcChannel,       // Channel number
    input wire logic [`GPA_ANALOG_W-1:0] analogChannelPins // Analog switches
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Reset itself is the cause here, so this one is never disabled
    chk_reset_clears_drive: assert property (disable iff (1'b0) !rstn |=> kbdPadOe == 4'h0 && kbdPullupOn == 4'h0 && analogPadOe == 6'h00 && analogChannelPins == 6'h00)
        else $error("drive or switch left on after reset");
    chk_pullup_not_out: assert property ((kbdPullupOn & kbdPadOe) == 4'h0)
        else $error("pullup on while pin drives");
    chk_dir_drives_pin: assert property (regWr && regAddr == `GPA_OFS_KBD_DIR |=> kbdPadOe == $past(regWrData[3:0]))
        else $error("direction write not on output enables");
    chk_latch_any_dir: assert property (regWr && regAddr == `GPA_OFS_KBD_LATCH |=> kbdPadOut == $past(regWrData[3:0]))
        else $error("latch write lost");
    chk_upper_bits_zero: assert property (regRd && (regAddr == `GPA_OFS_KBD_LATCH || regAddr == `GPA_OFS_KBD_DIR || regAddr == `GPA_OFS_KBD_PUE) |=> regRdData[7:4] == 4'h0)
        else $error("upper bits of keyboard register not zero");
    chk_unmapped_zero: assert property (regRd && (regAddr == 8'h03 || regAddr > `GPA_OFS_PLAIN_PUE) |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    // Sampled rstn keeps the release edge out: the design still resets there
    chk_analog_override: assert property (rstn && adcChannelValid && adcChannel < 3'h6 |=> analogChannelPins == (6'h01 << $past(adcChannel)) && (analogPadOe & analogChannelPins) == 6'h00)
        else $error("converter channel did not take the pin");
    chk_keypad_gated: assert property (1'b1 |=> (keypadInputs & ~$past(keypadIrqPinEnables)) == 4'h0)
        else $error("keypad input passed while disabled");
    chk_keypad_passes: assert property ((rstn && kbdPadIn[0] && keypadIrqPinEnables[0]) [*4] |-> keypadInputs[0])
        else $error("keypad input missed a steady high pin");
    cov_unmapped_read: cover property (regRd && (regAddr == 8'h03 || regAddr > `GPA_OFS_PLAIN_PUE));
    cov_analog_select: cover property (adcChannelValid && adcChannel < 3'h6);
    cov_pullup_on: cover property (kbdPullupOn != 4'h0);
endmodule // gpa_ports_abc_monitor

bind gpa_ports_abc gpa_ports_abc_monitor mon_u (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .kbdPadIn(kbdPadIn), .kbdPadOut(kbdPadOut),
    .kbdPadOe(kbdPadOe), .kbdPullupOn(kbdPullupOn), .analogPadOe(analogPadOe),
    .keypadIrqPinEnables(keypadIrqPinEnables), .keypadInputs(keypadInputs), .adcChannelValid(adcChannelValid),
    .adcChannel(adcChannel), .analogChannelPins(analogChannelPins));
`default_nettype wire

// [tb/gpa_pin_model.sv]
// Purpose: Board and pad model for one GPIO port
// Assumes: Bench sets external drive per pin
// Notes:   A pin nobody holds flips every cycle, so no stale level passes
`timescale 1ns/10ps
`default_nettype none
module gpa_pin_model
#(
    parameter int W = 4,
    parameter bit PU = 1'b1
)
(
    input wire logic clk,              // System clock
    input wire logic [W-1:0] padOut,   // Device drive value
    input wire logic [W-1:0] padOe,    // Device drive enable
    input wire logic [W-1:0] pullupOn, // Device pullup on
    input wire logic [W-1:0] extVal,   // Board drive value
    input wire logic [W-1:0] extDrv,   // Board drives pin
    output logic [W-1:0] padIn         // Resolved pin level
);
    logic [W-1:0] floatLvl = '0;

    // Floating level toggles against the last pin value
    always_ff @(posedge clk)
        floatLvl <= ~padIn;

    // device drive, then board, then pullup
    always_comb
        for (int i = 0; i < W; i++)
            padIn[i] = padOe[i] ? padOut[i] : extDrv[i] ? extVal[i] : (PU && pullupOn[i]) ? 1'b1 : floatLvl[i];
endmodule // gpa_pin_model
`default_nettype wire

// [tb/test_gpa_ports_abc.sv]
// Purpose: Self-checking bench for the three-port GPIO block
// Assumes: 25 MHz clock, synchronous active-low reset
// Notes:   Reference model keeps latch, direction and pullup per port
`timescale 1ns/10ps
`default_nettype none
`include "gpa_regs.svh"
module test_gpa_ports_abc;
    logic clk, rstn, regWr, regRd, adcChannelValid;
    logic [7:0] regAddr, regWrData, regRdData;
    logic [2:0] adcChannel;
    logic [3:0] kbdPadIn, kbdPadOut, kbdPadOe, kbdPullupOn, keypadIrqPinEnables, keypadInputs;
    logic [5:0] analogPadIn, analogPadOut, analogPadOe, analogChannelPins;
    logic [1:0] plainPadIn, plainPadOut, plainPadOe, plainPullupOn;
    logic [7:0] drvV [3];
    logic [7:0] drvE [3];
    int lat [3], dir [3], pue [3];
    int msk [3] = '{'h0f, 'h3f, 'h03};
    int rmap [9] = '{`GPA_OFS_KBD_LATCH, `GPA_OFS_ANALOG_LATCH, `GPA_OFS_PLAIN_LATCH, `GPA_OFS_KBD_DIR,
        `GPA_OFS_ANALOG_DIR, `GPA_OFS_PLAIN_DIR, `GPA_OFS_KBD_PUE, `GPA_OFS_PLAIN_PUE, 'h03};
    int errorCnt = 0, checked = 0, seed, r, seln;

    gpa_ports_abc dut_u (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .kbdPadIn(kbdPadIn), .kbdPadOut(kbdPadOut), .kbdPadOe(kbdPadOe),
        .kbdPullupOn(kbdPullupOn), .analogPadIn(analogPadIn), .analogPadOut(analogPadOut),
        .analogPadOe(analogPadOe), .plainPadIn(plainPadIn), .plainPadOut(plainPadOut), .plainPadOe(plainPadOe),
        .plainPullupOn(plainPullupOn), .keypadIrqPinEnables(keypadIrqPinEnables), .keypadInputs(keypadInputs),
        .adcChannelValid(adcChannelValid), .adcChannel(adcChannel), .analogChannelPins(analogChannelPins));
    gpa_pin_model pa_u (.clk(clk), .padOut(kbdPadOut), .padOe(kbdPadOe),
        .pullupOn(kbdPullupOn), .extVal(drvV[0][3:0]), .extDrv(drvE[0][3:0]), .padIn(kbdPadIn));
    gpa_pin_model #(.W(6)) pb_u (.clk(clk), .padOut(analogPadOut), .padOe(analogPadOe),
        .pullupOn(6'h00), .extVal(drvV[1][5:0]), .extDrv(drvE[1][5:0]), .padIn(analogPadIn));
    gpa_pin_model #(.W(2)) pc_u (.clk(clk), .padOut(plainPadOut), .padOe(plainPadOe),
        .pullupOn(plainPullupOn), .extVal(drvV[2][1:0]), .extDrv(drvE[2][1:0]), .padIn(plainPadIn));

    // ****************************************************************
    // Model, bus tasks and checks
    // ****************************************************************
    // Pin level the model can predict; undriven inputs without pullup are masked
    function automatic int pinv(int p);
        return (dir[p] & lat[p]) | (~dir[p] & int'(drvE[p] & drvV[p])) | (~dir[p] & ~int'(drvE[p]) & pue[p]);
    endfunction
    function automatic int pdet(int p);
        return dir[p] | int'(drvE[p]) | pue[p];
    endfunction
    function automatic int expR(int i);
        return i < 3 ? pinv(i) & msk[i] : i < 6 ? dir[i-3] : i == 6 ? pue[0] : i == 7 ? pue[2] : 0;
    endfunction

    task automatic conclude;
        if (errorCnt == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input int e, input int m);
        checked++;
        if ((got & m[7:0]) !== (e[7:0] & m[7:0]))
        begin
            errorCnt++;
            $display("unexpected at %0t got %h exp %h", $time, got, e[7:0]);
        end
    endtask
    // Write: one strobe cycle, model updated alongside
    task automatic mwr(input int i, input int d);
        @(posedge clk);
        regAddr <= rmap[i][7:0];
        regWrData <= d[7:0];
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        if (i < 3) lat[i] = d & msk[i];
        else if (i < 6) dir[i-3] = d & msk[i-3];
        else if (i == 6) pue[0] = d & 'h0f;
        else if (i == 7) pue[2] = d & 'h03;
    endtask
    // Read: data looked at in the single cycle after the strobe
    task automatic rd(input int i);
        @(posedge clk);
        regAddr <= rmap[i][7:0];
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        cmp(regRdData, expR(i), i < 3 ? pdet(i) | ~msk[i] : 'hff);
    endtask
    task automatic outs;
        seln = (adcChannelValid && adcChannel < 3'h6) ? 1 << adcChannel : 0;
        cmp(8'(kbdPadOe), dir[0], 'hff);
        cmp(8'(plainPadOe), dir[2], 'hff);
        cmp(8'(analogPadOe), dir[1] & ~seln, 'hff);
        cmp(8'(analogChannelPins), seln, 'hff);
        cmp(8'(kbdPadOut), lat[0], 'hff);
        cmp(8'(analogPadOut), lat[1], 'hff);
        cmp(8'(plainPadOut), lat[2], 'hff);
        cmp(8'(kbdPullupOn), pue[0] & ~dir[0] & 'h0f, 'hff);
        cmp(8'(plainPullupOn), pue[2] & ~dir[2] & 'h03, 'hff);
        cmp(8'(keypadInputs), pinv(0) & keypadIrqPinEnables, pdet(0) | ~int'(keypadIrqPinEnables));
    endtask

    // Clock at 40 ns
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Watchdog: about thirteen times the expected run
    initial
    begin
        #(40 * 20000);
        errorCnt++;
        conclude();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        rstn = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 8'h00; regWrData = 8'h00;
        adcChannelValid = 1'b0; adcChannel = 3'h0; keypadIrqPinEnables = 4'h0;
        drvV = '{8'h00, 8'h00, 8'h00};
        drvE = '{8'hff, 8'hff, 8'hff};
        dir = '{0, 0, 0};
        pue = '{0, 0, 0};
        seed = $urandom(4);
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 3; i < 8; i++) rd(i);
        // Latches first, so no pin glitches when a direction flips
        for (int i = 0; i < 3; i++) mwr(i, $urandom_range(255));
        repeat (60)
        begin
            r = $urandom_range(8);
            mwr(r, $urandom_range(255));
            @(posedge clk);
            for (int p = 0; p < 3; p++) drvV[p] <= 8'($urandom);
            for (int p = 0; p < 3; p++) drvE[p] <= 8'($urandom);
            keypadIrqPinEnables <= 4'($urandom);
            adcChannelValid <= 1'($urandom);
            adcChannel <= 3'($urandom);
            // Sync and keypad register need three edges
            repeat (4) @(posedge clk);
            #1;
            outs();
            for (int i = 0; i < 9; i++) rd(i);
        end
        // Mid-run reset keeps latches, clears directions and pullups
        mwr(3, 'h0f);
        mwr(6, 'h0f);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        dir = '{0, 0, 0};
        pue = '{0, 0, 0};
        repeat (4) @(posedge clk);
        #1;
        outs();
        for (int i = 3; i < 8; i++) rd(i);
        mwr(4, 'h30);
        repeat (4) @(posedge clk);
        #1;
        outs();
        conclude();
    end
endmodule // test_gpa_ports_abc
`default_nettype wire
